// ===== design/csr_bank.sv
`include "csr_params.svh"

// Notes on behaviour
// - Math register is operand and result of arithmetic and Boolean operations.
// - Multiply partner pairs with math register for multiply/divide, else scratch byte.
// - Push and call increment the stack pointer before the stack write.
// - Stack pointer resets to 07H so the first stacked byte lands at 08H.
// - Data pointer is a high and low byte, usable as one 16-bit value.
// - Status word at D0H, resets 00H, bit addressable, carries the flag fields.
// - Two bank-select bits pick one of four eight-register banks.
// - Power control at 87H, resets 00H, not bit addressable, bit 4 reserved.
// - Power control bit 7 doubles the serial baud rate.
// - Bits 6 and 5 enable serial and external-0 wake from power-down.
// - Bit 1 enters power-down, bit 0 idle; bits 3 and 2 are spare flags.
// - All visible registers except counter and banks sit in the register area.
// - Unoccupied addresses hold no storage; reads return zero with the hit flag clear.
// - Only addresses ending in 0H or 8H are bit addressable.
// - A dedicated register returns the silicon revision byte.
// - Calibration registers load factory values at reset, software may overwrite.
// - With master select clear, serial rate bit 0 reads the slave-select pin.
module csr_bank #(
  parameter logic [7:0] REVISION = 8'h5a,      // Revision byte, value arbitrary
  parameter logic [7:0] CAL_OFF_FACTORY = 8'h80,  // Factory offset coefficient
  parameter logic [7:0] CAL_GAIN_FACTORY = 8'h80  // Factory gain coefficient
) (
  input wire logic clk_sys,                 // Core clock
  input wire logic reset,                   // Synchronous reset, high
  input wire logic [7:0] sfr_addr,          // Direct byte address
  input wire logic sfr_wr,                  // Byte write strobe
  input wire logic sfr_rd,                  // Byte read strobe
  input wire logic [7:0] sfr_wdata,         // Byte write data
  output logic [7:0] sfr_rdata,             // Byte read data, next cycle
  output logic sfr_hit,                     // Read address was occupied
  input wire logic [7:0] bit_addr,          // Bit address
  input wire logic bit_wr,                  // Bit write strobe
  input wire logic bit_rd,                  // Bit read strobe
  input wire logic bit_wdata,               // Bit write value
  output logic bit_rdata,                   // Bit read data, next cycle
  input wire csr_pkg::csr_alu_s alu,        // Datapath results
  input wire logic stack_push,              // Push or call step
  input wire logic stack_pop,               // Pop or return step
  input wire logic ptr_we,                  // Load 16-bit pointer
  input wire logic [15:0] ptr_wdata,        // Pointer load value
  input wire logic ptr_inc,                 // Increment pointer
  input wire logic ss_pin,                  // Slave-select pin level
  output logic [7:0] math_register,         // Math register value
  output logic [7:0] multiply_partner,      // Partner register value
  output logic [7:0] stack_pointer,         // Stack top address
  output logic [15:0] data_pointer,         // Code address pointer
  output logic [7:0] cpu_status_word,       // Status word value
  output logic [7:0] bank_base,             // RAM base of active bank
  output csr_pkg::csr_power_s power,        // Power control decode
  output logic [7:0] serial_port_control,   // Serial control byte
  output logic [7:0] cal_offset,            // Offset coefficient
  output logic [7:0] cal_gain               // Gain coefficient
);

  csr_pkg::csr_state_s state;
  csr_pkg::csr_state_s next_state;
  logic [7:0] bit_byte_addr;
  logic [8:0] bit_byte_read;
  logic bit_value;
  logic [7:0] bit_merged;
  logic bit_in_sfr;

  // Read decode shared by byte and bit access; {hit, data}
  function automatic logic [8:0] csr_read(input csr_pkg::csr_state_s s, input logic [7:0] a);
    case (a)
      `CSR_ADDR_MATH: csr_read = {1'b1, s.math};
      `CSR_ADDR_PARTNER: csr_read = {1'b1, s.partner};
      `CSR_ADDR_STACK: csr_read = {1'b1, s.stack};
      `CSR_ADDR_PTR_LOW: csr_read = {1'b1, s.ptr_low};
      `CSR_ADDR_PTR_HIGH: csr_read = {1'b1, s.ptr_high};
      `CSR_ADDR_STATUS: csr_read = {1'b1, s.status};
      `CSR_ADDR_POWER: csr_read = {1'b1, s.pwr & `CSR_PWR_MASK};
      `CSR_ADDR_REV: csr_read = {1'b1, REVISION};
      `CSR_ADDR_CAL_OFF: csr_read = {1'b1, s.cal_off};
      `CSR_ADDR_CAL_GAIN: csr_read = {1'b1, s.cal_gain};
      `CSR_ADDR_SERIAL_CTRL: begin
        csr_read = {1'b1, s.serial_ctrl};
        if (!s.serial_ctrl[`CSR_SPI_MASTER]) begin
          csr_read[`CSR_SPI_RATE0] = s.ss_sync;
        end
      end
      // No storage behind unoccupied or reserved addresses; zero is returned
      default: csr_read = 9'h000;
    endcase
  endfunction

  assign bit_byte_read = csr_read(state, bit_byte_addr);

  csr_bit_unit u_bit (
    .bit_addr(bit_addr),
    .byte_value(bit_byte_read[7:0]),
    .bit_wdata(bit_wdata),
    .byte_addr(bit_byte_addr),
    .bit_value(bit_value),
    .merged_byte(bit_merged),
    .in_sfr(bit_in_sfr)
  );

  // Next-state logic; later assignments win, so software writes beat datapath updates
  always_comb begin
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    next_state = state;
    // Pin passes two flops before the read mux sees it
    next_state.ss_meta = ss_pin;
    next_state.ss_sync = state.ss_meta;
    // Datapath results land in math and partner registers
    if (alu.math_we) begin
      next_state.math = alu.math;
    end
    if (alu.partner_we) begin
      next_state.partner = alu.partner;
    end
    if (alu.flags_we) begin
      next_state.status[`CSR_STAT_CARRY] = alu.carry;
      next_state.status[`CSR_STAT_HALF] = alu.half;
      next_state.status[`CSR_STAT_WRAP] = alu.wrap;
    end
    // Pre-increment on push so the write address is the new top
    if (stack_push) begin
      next_state.stack = state.stack + 8'h01;
    end else if (stack_pop) begin
      next_state.stack = state.stack - 8'h01;
    end
    // Pointer as one 16-bit value over two byte registers
    if (ptr_we) begin
      {next_state.ptr_high, next_state.ptr_low} = ptr_wdata;
    end else if (ptr_inc) begin
      {next_state.ptr_high, next_state.ptr_low} = {state.ptr_high, state.ptr_low} + 16'h0001;
    end
    // Byte write beats a bit write in the same cycle
    if (sfr_wr) begin
      wr_en = 1'b1;
      wr_addr = sfr_addr;
      wr_data = sfr_wdata;
    end else if (bit_wr && bit_in_sfr) begin
      wr_en = 1'b1;
      wr_addr = bit_byte_addr;
      wr_data = bit_merged;
    end
    if (wr_en) begin
      case (wr_addr)
        `CSR_ADDR_MATH: next_state.math = wr_data;
        `CSR_ADDR_PARTNER: next_state.partner = wr_data;
        `CSR_ADDR_STACK: next_state.stack = wr_data;
        `CSR_ADDR_PTR_LOW: next_state.ptr_low = wr_data;
        `CSR_ADDR_PTR_HIGH: next_state.ptr_high = wr_data;
        `CSR_ADDR_STATUS: next_state.status = wr_data;
        `CSR_ADDR_POWER: next_state.pwr = wr_data & `CSR_PWR_MASK;
        `CSR_ADDR_CAL_OFF: next_state.cal_off = wr_data;
        `CSR_ADDR_CAL_GAIN: next_state.cal_gain = wr_data;
        `CSR_ADDR_SERIAL_CTRL: next_state.serial_ctrl = wr_data;
        // Writes to the revision byte and empty space are dropped
        default: next_state.cal_off = next_state.cal_off;
      endcase
    end
    // Parity is pure hardware; any written value is overridden here
    next_state.status[`CSR_STAT_PARITY] = ^next_state.math;
    // Registered read answers, zero when idle
    next_state.rdata = 8'h00;
    next_state.hit = 1'b0;
    if (sfr_rd) begin
      {next_state.hit, next_state.rdata} = csr_read(state, sfr_addr);
    end
    next_state.bit_rdata = bit_rd && bit_in_sfr && bit_value;
    // Reset also reloads factory coefficients
    if (reset) begin
      next_state.math = `CSR_RST_MATH;
      next_state.partner = `CSR_RST_PARTNER;
      next_state.stack = `CSR_RST_STACK;
      next_state.ptr_low = `CSR_RST_PTR_LOW;
      next_state.ptr_high = `CSR_RST_PTR_HIGH;
      next_state.status = `CSR_RST_STATUS;
      next_state.pwr = `CSR_RST_POWER;
      next_state.serial_ctrl = `CSR_RST_SERIAL_CTRL;
      next_state.cal_off = CAL_OFF_FACTORY;
      next_state.cal_gain = CAL_GAIN_FACTORY;
      next_state.rdata = 8'h00;
      next_state.hit = 1'b0;
      next_state.bit_rdata = 1'b0;
      next_state.ss_meta = 1'b0;
      next_state.ss_sync = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    state <= next_state;
  end

  // Outputs straight from state flops
  assign math_register = state.math;
  assign multiply_partner = state.partner;
  assign stack_pointer = state.stack;
  assign data_pointer = {state.ptr_high, state.ptr_low};
  assign cpu_status_word = state.status;
  assign bank_base = {3'b000, state.status[`CSR_STAT_BANK_HI:`CSR_STAT_BANK_LO], 3'b000};
  assign serial_port_control = state.serial_ctrl;
  assign cal_offset = state.cal_off;
  assign cal_gain = state.cal_gain;
  assign sfr_rdata = state.rdata;
  assign sfr_hit = state.hit;
  assign bit_rdata = state.bit_rdata;

  // Power control decode; the reserved bit never leaves the block
  always_comb begin
    power.baud_double = state.pwr[`CSR_PWR_BAUD];
    power.serial_wake_enable = state.pwr[`CSR_PWR_SER_WAKE];
    power.ext_irq0_wake_enable = state.pwr[`CSR_PWR_IRQ0_WAKE];
    power.spare_flag_one = state.pwr[`CSR_PWR_SPARE1];
    power.spare_flag_zero = state.pwr[`CSR_PWR_SPARE0];
    power.deep_sleep_enable = state.pwr[`CSR_PWR_DEEP];
    power.halt_cpu_enable = state.pwr[`CSR_PWR_HALT];
  end

  // Checks on the bank
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Software writes to the stack byte win, so the step checks skip them
  logic stack_sfr_wr;
  assign stack_sfr_wr = sfr_wr && (sfr_addr == `CSR_ADDR_STACK);

  // Occupancy of the current read address, for the empty-space check
  logic [8:0] rd_probe;
  assign rd_probe = csr_read(state, sfr_addr);

  AST_STACK_RESET: assert property ($past(reset) |-> stack_pointer == 8'h07)
    else $error("stack pointer not 07 after reset");

  AST_PUSH_PRE_INC: assert property (stack_push && !stack_sfr_wr
    |=> stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push did not pre-increment");

  AST_POP_DEC: assert property (stack_pop && !stack_push && !stack_sfr_wr
    |=> stack_pointer == $past(stack_pointer) - 8'h01)
    else $error("pop did not decrement");

  // Pointer bytes are not bit addressable, so only byte writes interfere
  AST_PTR_INC: assert property (ptr_inc && !ptr_we && !sfr_wr
    |=> data_pointer == $past(data_pointer) + 16'h0001)
    else $error("pointer increment lost");

  AST_MATH_RESULT: assert property (alu.math_we && !sfr_wr && !bit_wr
    |=> math_register == $past(alu.math))
    else $error("math result lost");

  AST_READ_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("read data without a read");

  AST_BIT_IDLE: assert property (!(bit_rd && bit_addr[7]) |=> !bit_rdata)
    else $error("bit data outside register area");

  AST_STATUS_WRITE: assert property (sfr_wr && sfr_addr == 8'hd0
    |=> cpu_status_word[7:1] == $past(sfr_wdata[7:1]))
    else $error("status word write lost");

  AST_SLEEP_MODES: assert property (sfr_wr && sfr_addr == 8'h87
    |=> power.halt_cpu_enable == $past(sfr_wdata[0]) && power.deep_sleep_enable == $past(sfr_wdata[1]))
    else $error("sleep mode bits not taken");

  AST_WAKE: assert property (sfr_wr && sfr_addr == 8'h87
    |=> power.serial_wake_enable == $past(sfr_wdata[6]) && power.ext_irq0_wake_enable == $past(sfr_wdata[5]))
    else $error("wake enables not taken");

  AST_PARITY: assert property (cpu_status_word[0] == ^math_register)
    else $error("parity flag disagrees with math register");

  AST_BANK_BASE: assert property (bank_base[2:0] == 3'b000 && bank_base[7:5] == 3'b000
    && bank_base[4:3] == cpu_status_word[4:3])
    else $error("bank base wrong");

  AST_POWER_RSVD: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_hit && !sfr_rdata[4])
    else $error("reserved power bit read back set");

  AST_UNMAPPED: assert property (sfr_rd && !rd_probe[8]
    |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unoccupied address answered");

  AST_NO_BIT_POWER_CONTROL: assert property (bit_wr && !sfr_wr |=> power == $past(power))
    else $error("bit write altered power control");

  AST_REVISION: assert property (sfr_rd && sfr_addr == 8'hc2 |=> sfr_rdata == REVISION)
    else $error("revision byte wrong");

  AST_CAL_RESET: assert property ($past(reset) |-> cal_offset == CAL_OFF_FACTORY
    && cal_gain == CAL_GAIN_FACTORY)
    else $error("calibration not reloaded");

  AST_SS_REFLECT: assert property (sfr_rd && sfr_addr == 8'hf8 && !state.serial_ctrl[4]
    |=> sfr_rdata[0] == $past(state.ss_sync))
    else $error("rate bit does not follow slave select");

  AST_PTR_LOAD: assert property (ptr_we && !sfr_wr |=> data_pointer == $past(ptr_wdata))
    else $error("pointer load lost");

  AST_PARTNER: assert property (alu.partner_we && !sfr_wr && !bit_wr
    |=> multiply_partner == $past(alu.partner))
    else $error("partner result lost");

  AST_BAUD: assert property (sfr_wr && sfr_addr == 8'h87 |=> power.baud_double == $past(sfr_wdata[7]))
    else $error("baud double not taken");

endmodule

// ===== design/csr_bit_unit.sv
module csr_bit_unit (
  input wire logic [7:0] bit_addr,    // Bit address from the core
  input wire logic [7:0] byte_value,  // Current value of the owning byte
  input wire logic bit_wdata,         // Bit value to write
  output logic [7:0] byte_addr,       // Owning byte address
  output logic bit_value,             // Selected bit of the byte
  output logic [7:0] merged_byte,     // Byte with the bit replaced
  output logic in_sfr                 // Bit lies in the register area
);

  // Upper half of bit space maps onto bytes ending in 0H or 8H only
  always_comb begin
    in_sfr = bit_addr[7];
    byte_addr = {bit_addr[7:3], 3'b000};
    bit_value = byte_value[bit_addr[2:0]];
    merged_byte = byte_value;
    merged_byte[bit_addr[2:0]] = bit_wdata;
  end

endmodule

// ===== design/csr_params.svh
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// Special-function byte addresses
`define CSR_ADDR_POWER 8'h87
`define CSR_ADDR_STATUS 8'hd0
`define CSR_ADDR_MATH 8'he0
`define CSR_ADDR_PARTNER 8'hf0
`define CSR_ADDR_STACK 8'h81
`define CSR_ADDR_PTR_LOW 8'h82
`define CSR_ADDR_PTR_HIGH 8'h83
`define CSR_ADDR_REV 8'hc2
`define CSR_ADDR_CAL_OFF 8'hd9
`define CSR_ADDR_CAL_GAIN 8'hda
`define CSR_ADDR_SERIAL_CTRL 8'hf8

// Status word field positions
`define CSR_STAT_CARRY 7
`define CSR_STAT_HALF 6
`define CSR_STAT_USER0 5
`define CSR_STAT_BANK_HI 4
`define CSR_STAT_BANK_LO 3
`define CSR_STAT_WRAP 2
`define CSR_STAT_USER1 1
`define CSR_STAT_PARITY 0

// Power control field positions
`define CSR_PWR_BAUD 7
`define CSR_PWR_SER_WAKE 6
`define CSR_PWR_IRQ0_WAKE 5
`define CSR_PWR_RSVD 4
`define CSR_PWR_SPARE1 3
`define CSR_PWR_SPARE0 2
`define CSR_PWR_DEEP 1
`define CSR_PWR_HALT 0
`define CSR_PWR_MASK 8'hef

// Serial control field positions
`define CSR_SPI_MASTER 4
`define CSR_SPI_RATE0 0

// Reset values
`define CSR_RST_MATH 8'h00
`define CSR_RST_PARTNER 8'h00
`define CSR_RST_STACK 8'h07
`define CSR_RST_PTR_LOW 8'h00
`define CSR_RST_PTR_HIGH 8'h00
`define CSR_RST_STATUS 8'h00
`define CSR_RST_POWER 8'h00
`define CSR_RST_SERIAL_CTRL 8'h00

`endif

// ===== design/csr_pkg.sv
package csr_pkg;

  // Core datapath update bundle
  typedef struct packed {
    logic math_we;
    logic [7:0] math;
    logic partner_we;
    logic [7:0] partner;
    logic flags_we;
    logic carry;
    logic half;
    logic wrap;
  } csr_alu_s;

  // Power control decode toward clock and wake logic
  typedef struct packed {
    logic baud_double;
    logic serial_wake_enable;
    logic ext_irq0_wake_enable;
    logic spare_flag_one;
    logic spare_flag_zero;
    logic deep_sleep_enable;
    logic halt_cpu_enable;
  } csr_power_s;

  // All state of the register bank
  typedef struct packed {
    logic [7:0] math;
    logic [7:0] partner;
    logic [7:0] stack;
    logic [7:0] ptr_low;
    logic [7:0] ptr_high;
    logic [7:0] status;
    logic [7:0] pwr;
    logic [7:0] serial_ctrl;
    logic [7:0] cal_off;
    logic [7:0] cal_gain;
    logic [7:0] rdata;
    logic hit;
    logic bit_rdata;
    logic ss_meta;
    logic ss_sync;
  } csr_state_s;

endpackage

// ===== verification/tb_csr_bank.sv
module tb_csr_bank;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [7:0] bit_addr = 8'h00;
  logic bit_wr = 1'b0;
  logic bit_rd = 1'b0;
  logic bit_wdata = 1'b0;
  logic bit_rdata;
  csr_pkg::csr_alu_s alu = '0;
  logic stack_push = 1'b0;
  logic stack_pop = 1'b0;
  logic ptr_we = 1'b0;
  logic [15:0] ptr_wdata = 16'h0000;
  logic ptr_inc = 1'b0;
  logic ss_pin = 1'b0;
  logic [7:0] math_register;
  logic [7:0] multiply_partner;
  logic [7:0] stack_pointer;
  logic [15:0] data_pointer;
  logic [7:0] cpu_status_word;
  logic [7:0] bank_base;
  csr_pkg::csr_power_s power;
  logic [7:0] serial_port_control;
  logic [7:0] cal_offset;
  logic [7:0] cal_gain;
  int miscompares = 0;
  int checked = 0;
  int seed = 64;
  int m[256];
  // Occupied plain bytes only; reserved addresses are never touched
  int regs[$] = '{8'he0, 8'hf0, 8'h81, 8'h82, 8'h83, 8'hd9, 8'hda};
  logic [7:0] v;

  csr_bank csr_bank_i (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata), .alu(alu), .stack_push(stack_push), .stack_pop(stack_pop),
    .ptr_we(ptr_we), .ptr_wdata(ptr_wdata), .ptr_inc(ptr_inc), .ss_pin(ss_pin),
    .math_register(math_register), .multiply_partner(multiply_partner),
    .stack_pointer(stack_pointer), .data_pointer(data_pointer), .cpu_status_word(cpu_status_word),
    .bank_base(bank_base), .power(power), .serial_port_control(serial_port_control),
    .cal_offset(cal_offset), .cal_gain(cal_gain));

  // Free-running core clock, 20 ns period
  always #10 clk_sys = ~clk_sys;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Status word as the model sees it; parity always follows the math register
  function automatic logic [7:0] status_exp();
    logic [7:0] p;
    p = 8'(m[8'hd0]);
    return {p[7:1], ^8'(m[8'he0])};
  endfunction

  // Byte write; s is what the model expects to be stored
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] s);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #2;
    sfr_wr = 1'b0;
    m[a] = s;
    // Idle cycle so a following strobe is not raised in the same step
    @(posedge clk_sys);
    #2;
  endtask

  // Byte read; data and hit stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #2;
    sfr_rd = 1'b0;
    check(sfr_rdata, e);
    check({7'h00, sfr_hit}, {7'h00, h});
    @(posedge clk_sys);
    #2;
  endtask

  task automatic bwr(input logic [7:0] a, input logic d);
    bit_addr = a;
    bit_wdata = d;
    bit_wr = 1'b1;
    @(posedge clk_sys);
    #2;
    bit_wr = 1'b0;
    @(posedge clk_sys);
    #2;
  endtask

  task automatic brd(input logic [7:0] a, input logic e);
    bit_addr = a;
    bit_rd = 1'b1;
    @(posedge clk_sys);
    #2;
    bit_rd = 1'b0;
    check({7'h00, bit_rdata}, {7'h00, e});
    @(posedge clk_sys);
    #2;
  endtask

  // One-cycle strobe on a datapath input
  task automatic step();
    @(posedge clk_sys);
    #2;
    alu = '0;
    stack_push = 1'b0;
    stack_pop = 1'b0;
    ptr_we = 1'b0;
    ptr_inc = 1'b0;
  endtask

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end

  initial begin
    foreach (m[i]) m[i] = 0;
    m[8'h81] = 8'h07;
    repeat (12) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    check(stack_pointer, 8'h07);
    check(cpu_status_word, 8'h00);
    check({1'b0, power}, 8'h00);
    check(cal_offset, 8'h80);
    check(cal_gain, 8'h80);
    rd(8'hc2, 8'h5a, 1'b1);
    wr(8'hc2, 8'h00, 8'h00);
    rd(8'hc2, 8'h5a, 1'b1);
    // Push from reset lands on 08, pop returns
    stack_push = 1'b1;
    step();
    check(stack_pointer, 8'h08);
    stack_pop = 1'b1;
    step();
    check(stack_pointer, 8'h07);
    // Random fill of every plain byte register, then read back
    foreach (regs[i]) begin
      v = 8'($random(seed));
      wr(8'(regs[i]), v, v);
    end
    foreach (regs[i]) rd(8'(regs[i]), 8'(m[regs[i]]), 1'b1);
    check(math_register, 8'(m[8'he0]));
    check(multiply_partner, 8'(m[8'hf0]));
    check(data_pointer[15:8], 8'(m[8'h83]));
    check(data_pointer[7:0], 8'(m[8'h82]));
    check(cal_offset, 8'(m[8'hd9]));
    check(cal_gain, 8'(m[8'hda]));
    check(cpu_status_word, status_exp());
    // Unoccupied address keeps nothing and reads empty
    wr(8'h84, 8'hff, 8'h00);
    rd(8'h84, 8'h00, 1'b0);
    // Every power control bit alone; bit 4 never stores
    for (int k = 0; k < 8; k++) begin
      v = 8'h01 << k;
      wr(8'h87, v, v & 8'hef);
      check({1'b0, power}, {1'b0, v[7:5], v[3:0]});
      rd(8'h87, v & 8'hef, 1'b1);
    end
    // Bank select codes; a written parity bit is ignored
    for (int k = 0; k < 4; k++) begin
      wr(8'hd0, 8'((k << 3) | 1), 8'(k << 3));
      check(bank_base, 8'(k * 8));
      rd(8'hd0, status_exp(), 1'b1);
    end
    // Datapath results through the math and partner registers
    alu.math_we = 1'b1;
    alu.math = 8'($random(seed));
    alu.partner_we = 1'b1;
    alu.partner = 8'($random(seed));
    alu.flags_we = 1'b1;
    alu.carry = 1'b1;
    alu.wrap = 1'b1;
    m[8'he0] = alu.math;
    m[8'hf0] = alu.partner;
    m[8'hd0] = (m[8'hd0] & 8'h3a) | 8'h84;
    step();
    check(math_register, 8'(m[8'he0]));
    check(multiply_partner, 8'(m[8'hf0]));
    check(cpu_status_word, status_exp());
    // Bit access only on registers ending in 0 or 8
    bwr(8'hd5, 1'b1);
    m[8'hd0] = m[8'hd0] | 8'h20;
    check(cpu_status_word, status_exp());
    brd(8'hd5, 1'b1);
    v = 8'(m[8'he0]);
    bwr(8'he3, ~v[3]);
    m[8'he0] = m[8'he0] ^ 8'h08;
    check(math_register, 8'(m[8'he0]));
    brd(8'hd0, ^8'(m[8'he0]));
    // Pointer load, carry into high byte, then a lone low-byte write
    ptr_we = 1'b1;
    ptr_wdata = 16'h12ff;
    step();
    ptr_inc = 1'b1;
    step();
    rd(8'h83, 8'h13, 1'b1);
    rd(8'h82, 8'h00, 1'b1);
    wr(8'h82, 8'h34, 8'h34);
    check(data_pointer[15:8], 8'h13);
    check(data_pointer[7:0], 8'h34);
    // Slave-select level shows in rate bit 0 only while master select is clear
    wr(8'hf8, 8'h00, 8'h00);
    ss_pin = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2;
    rd(8'hf8, 8'h01, 1'b1);
    wr(8'hf8, 8'h10, 8'h10);
    check(serial_port_control, 8'h10);
    rd(8'hf8, 8'h10, 1'b1);
    ss_pin = 1'b0;
    wr(8'hf8, 8'h00, 8'h00);
    repeat (3) @(posedge clk_sys);
    #2;
    rd(8'hf8, 8'h00, 1'b1);
    end_of_test();
  end
endmodule
